// >>> design/target_input_conditioner.sv
// Input front end: derives a 0..4095 target from serial, analog or pulse input.
// Assumes synchronous inputs, a decoded serial command and a 10-bit ADC stream.
//
// Behaviour
// - Serial mode takes target only from accepted serial commands.
// - Analog conversion is linear, 0 V gives 0, full scale gives 4092.
// - Pulse mode raw input is high time in two-thirds microsecond ticks.
// - Pulses outside 400..2600 us are invalid; source sends 10..150 Hz.
// - Pulse raw updates only after four consecutive valid pulses.
// - Stale-pulse error when over 120 ms pass without update.
// - Raw between minimum and maximum maps onto target endpoints.
// - Raw within neutral bounds maps to neutral target, forming a dead band.
// - Out-of-range error when raw lies outside absolute limits, in analog and pulse modes only.
// - Inversion swaps the positive and negative directions.
// - Linear by default; higher degree flattens the curve near neutral.
// - Analog mode averages a configurable number of samples per period.
// - Period overrun flag when sampling outlasts the control period.
// - Disconnect probe drives aux low, nonzero reading gives range error.
// - Serial timeout error after configured time; zero disables it.
// - With checksum enabled every command must carry a good CRC byte.
// - A configurable unit number selects this unit on a shared line.
// - Each probe holds aux low about 150 us once per period.
// - Raw input and target are unsigned 0..4095.
`timescale 1ns/1ns
`default_nettype none
`include "target_input_conditioner_cfg.svh"
module target_input_conditioner #(
  parameter int MS_CYC    = `MS_CYCLES,
  parameter int STALE_CYC = `STALE_CYCLES,
  parameter int PROBE_CYC = `PROBE_CYCLES
) (
  input  wire logic                                       sys_clk_i,
  input  wire logic                                       rst_n_i,
  input  wire logic [7:0]                                 addr_i,
  input  wire logic [31:0]                                wdata_i,
  input  wire logic                                       wr_i,
  input  wire logic                                       rd_i,
  output logic      [31:0]                                rdata_o,
  input  wire target_input_conditioner_pkg::serial_cmd_t  cmd_i,
  input  wire logic                                       adc_valid_i,
  input  wire logic [9:0]                                 adc_data_i,
  input  wire logic                                       rx_pin_i,
  output logic                                            aux_o,
  output logic                                            aux_oe_o,
  output logic      [11:0]                                target_o,
  output logic                                            stale_err_o,
  output logic                                            range_err_o,
  output logic                                            serial_to_err_o,
  output logic                                            period_overrun_flag_o
);
  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [31:0] cfg_reg [`NUM_CFG];
  logic [1:0]  mode;
  logic [6:0]  unit;
  logic [1:0]  degree;
  logic [7:0]  period_ms;
  logic [2:0]  samp_log2;
  logic [11:0] in_min, in_max, n_min, n_max, a_min, a_max, t_min, t_max, n_tgt;
  logic [15:0] timeout_ms;
  assign mode       = cfg_reg[0][1:0];
  assign degree     = cfg_reg[0][6:5];
  assign unit       = cfg_reg[0][14:8];
  assign period_ms  = cfg_reg[1][7:0];
  assign samp_log2  = cfg_reg[1][10:8];
  assign in_min     = cfg_reg[2][11:0];
  assign in_max     = cfg_reg[2][27:16];
  assign n_min      = cfg_reg[3][11:0];
  assign n_max      = cfg_reg[3][27:16];
  assign a_min      = cfg_reg[4][11:0];
  assign a_max      = cfg_reg[4][27:16];
  assign t_min      = cfg_reg[5][11:0];
  assign t_max      = cfg_reg[5][27:16];
  assign n_tgt      = cfg_reg[6][11:0];
  assign timeout_ms = cfg_reg[6][31:16];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg[0] <= `RST_CTRL;
      cfg_reg[1] <= `RST_PERIOD;
      cfg_reg[2] <= `RST_RANGE;
      cfg_reg[3] <= `RST_NEUTRAL;
      cfg_reg[4] <= `RST_RANGE;
      cfg_reg[5] <= `RST_RANGE;
      cfg_reg[6] <= `RST_NTGT;
    end else if (wr_i && addr_i < `ADDR_VALUES && addr_i[1:0] == 2'h0) begin
      cfg_reg[addr_i[4:2]] <= wdata_i;
    end
  end

  // ----------------------------------------
  // Millisecond and control period timing
  // ----------------------------------------
  logic [17:0] ms_cnt_reg;
  logic [7:0]  per_cnt_reg;
  logic        ms_tick, period_tick;
  assign ms_tick     = (ms_cnt_reg == 18'(MS_CYC - 1));
  assign period_tick = ms_tick && (per_cnt_reg + 8'h01 >= period_ms);
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_reg  <= 18'h0;
      per_cnt_reg <= 8'h0;
    end else begin
      ms_cnt_reg <= ms_tick ? 18'h0 : ms_cnt_reg + 18'h1;
      if (period_tick) per_cnt_reg <= 8'h0;
      else if (ms_tick) per_cnt_reg <= per_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // Serial commands and timeout
  // ----------------------------------------
  logic        cmd_ok;
  logic [15:0] to_ms_reg;
  assign cmd_ok = cmd_i.valid && cmd_i.unit == unit && mode == `MODE_SERIAL
                  && (!cfg_reg[0][3] || (cmd_i.has_crc && cmd_i.crc_ok));
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      to_ms_reg       <= 16'h0;
      serial_to_err_o <= 1'b0;
    end else begin
      if (cmd_ok) to_ms_reg <= 16'h0;
      else if (ms_tick && to_ms_reg != 16'hFFFF) to_ms_reg <= to_ms_reg + 16'h1;
      if (period_tick) serial_to_err_o <= timeout_ms != 16'h0 && to_ms_reg >= timeout_ms;
    end
  end

  // ----------------------------------------
  // Pulse width measurement
  // ----------------------------------------
  logic        rx_q_reg, pulse_up;
  logic [8:0]  tick_acc_reg;
  logic [12:0] hi_tk_reg;
  logic [2:0]  good_reg;
  logic [11:0] pulse_raw;
  logic [31:0] stale_reg;
  logic        pulse_ok;
  assign pulse_ok = hi_tk_reg >= 13'(`PULSE_MIN_TK) && hi_tk_reg <= 13'(`PULSE_MAX_TK);
  assign pulse_up = rx_q_reg && !rx_pin_i && pulse_ok && good_reg >= 3'(`GOOD_PULSES - 1);
  assign pulse_raw = hi_tk_reg[11:0];
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_q_reg     <= 1'b0;
      tick_acc_reg <= 9'h0;
      hi_tk_reg    <= 13'h0;
      good_reg     <= 3'h0;
      stale_reg    <= 32'h0;
      stale_err_o  <= 1'b0;
    end else begin
      rx_q_reg <= rx_pin_i;
      if (rx_pin_i && !rx_q_reg) begin
        tick_acc_reg <= 9'h0;
        hi_tk_reg    <= 13'h0;
      end else if (rx_pin_i) begin
        if (tick_acc_reg + 9'(`TICK_ADD) >= 9'(`TICK_WRAP)) begin
          tick_acc_reg <= tick_acc_reg + 9'(`TICK_ADD) - 9'(`TICK_WRAP);
          if (hi_tk_reg != 13'h1FFF) hi_tk_reg <= hi_tk_reg + 13'h1;
        end else begin
          tick_acc_reg <= tick_acc_reg + 9'(`TICK_ADD);
        end
      end
      if (rx_q_reg && !rx_pin_i) begin
        if (!pulse_ok) good_reg <= 3'h0;
        else if (good_reg < 3'(`GOOD_PULSES)) good_reg <= good_reg + 3'h1;
      end
      if (pulse_up || mode != `MODE_PULSE) stale_reg <= 32'h0;
      else if (stale_reg <= 32'(STALE_CYC)) stale_reg <= stale_reg + 32'h1;
      stale_err_o <= mode == `MODE_PULSE && stale_reg > 32'(STALE_CYC);
    end
  end

  // ----------------------------------------
  // Analog averaging and disconnect probe
  // ----------------------------------------
  logic [17:0] sum_reg;
  logic [7:0]  samp_reg;
  logic        done_reg, probing, probe_bad_reg, probe_err_reg, ana_up;
  logic [15:0] probe_cnt_reg;
  logic [17:0] sum_next;
  logic [11:0] ana_raw;
  assign probing  = probe_cnt_reg != 16'h0;
  assign sum_next = sum_reg + {8'h0, adc_data_i};
  assign ana_up   = adc_valid_i && !probing && !done_reg && mode == `MODE_ANALOG
                    && samp_reg + 8'h01 == 8'(1 << samp_log2);
  assign ana_raw  = {10'(sum_next >> samp_log2), 2'h0};
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_reg       <= 18'h0;
      samp_reg      <= 8'h0;
      done_reg      <= 1'b0;
      probe_cnt_reg <= 16'h0;
      probe_bad_reg <= 1'b0;
      probe_err_reg <= 1'b0;
      aux_o         <= 1'b1;
      aux_oe_o      <= 1'b0;
    end else begin
      aux_oe_o <= 1'b1;
      if (period_tick) begin
        sum_reg  <= 18'h0;
        samp_reg <= 8'h0;
        done_reg <= 1'b0;
        probe_bad_reg <= 1'b0;
        if (mode == `MODE_ANALOG && cfg_reg[0][4]) probe_cnt_reg <= 16'(PROBE_CYC);
      end else begin
        if (probing) probe_cnt_reg <= probe_cnt_reg - 16'h1;
        if (probing && adc_valid_i) probe_bad_reg <= adc_data_i != 10'h0;
        if (probe_cnt_reg == 16'h1) probe_err_reg <= probe_bad_reg;
        if (adc_valid_i && !probing && !done_reg) begin
          sum_reg  <= sum_next;
          samp_reg <= samp_reg + 8'h01;
          if (ana_up) done_reg <= 1'b1;
        end
      end
      if (mode != `MODE_ANALOG || !cfg_reg[0][4]) probe_err_reg <= 1'b0;
      aux_o <= !(probing && !period_tick && probe_cnt_reg != 16'h1);
    end
  end

  // Overrun: set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) period_overrun_flag_o <= 1'b0;
    else if (period_tick && mode == `MODE_ANALOG && !done_reg) period_overrun_flag_o <= 1'b1;
    else if (wr_i && addr_i == `ADDR_FLAGS && wdata_i[`FLAG_OVERRUN]) period_overrun_flag_o <= 1'b0;
  end

  // ----------------------------------------
  // Raw input and range check
  // ----------------------------------------
  logic [11:0] raw_reg;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_reg     <= 12'h0;
      range_err_o <= 1'b0;
    end else begin
      if (cmd_ok) raw_reg <= cmd_i.target;
      else if (ana_up) raw_reg <= ana_raw;
      else if (pulse_up && mode == `MODE_PULSE) raw_reg <= pulse_raw;
      range_err_o <= probe_err_reg || (mode != `MODE_SERIAL
                     && (raw_reg < a_min || raw_reg > a_max));
    end
  end

  // ----------------------------------------
  // Scaling engine, once per period
  // ----------------------------------------
  target_input_conditioner_pkg::scale_state_t st_reg;
  logic        hi_reg;
  logic [3:0]  step_reg;
  logic [12:0] rem_reg, den_reg, q_reg, lin_reg;
  logic [1:0]  pow_reg;
  logic [11:0] num, den;
  logic [13:0] rem2;
  logic [25:0] sq;
  logic signed [13:0] span;
  logic signed [27:0] prod;
  assign num  = raw_reg > n_max ? raw_reg - n_max : n_min - raw_reg;
  assign den  = raw_reg > n_max ? in_max - n_max : n_min - in_min;
  assign rem2 = {rem_reg, 1'b0};
  assign sq   = q_reg * lin_reg;
  assign span = (hi_reg ^ cfg_reg[0][2]) ? $signed({2'h0, t_max}) - $signed({2'h0, n_tgt})
                                         : $signed({2'h0, t_min}) - $signed({2'h0, n_tgt});
  assign prod = $signed({1'b0, q_reg}) * span;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg   <= target_input_conditioner_pkg::S_IDLE;
      hi_reg   <= 1'b0;
      step_reg <= 4'h0;
      rem_reg  <= 13'h0;
      den_reg  <= 13'h0;
      q_reg    <= 13'h0;
      lin_reg  <= 13'h0;
      pow_reg  <= 2'h0;
      target_o <= 12'h0;
    end else begin
      case (st_reg)
        target_input_conditioner_pkg::S_IDLE: begin
          if (cmd_ok) target_o <= cmd_i.target;
          else if (period_tick && mode != `MODE_SERIAL) begin
            hi_reg <= raw_reg > n_max;
            pow_reg <= degree > 2'h1 ? degree - 2'h1 : 2'h0;
            if (raw_reg <= n_max && raw_reg >= n_min) target_o <= n_tgt;
            else if (num >= den) begin
              q_reg  <= `FULL_FRAC;
              st_reg <= target_input_conditioner_pkg::S_POW;
            end else begin
              rem_reg  <= {1'b0, num};
              den_reg  <= {1'b0, den};
              q_reg    <= 13'h0;
              step_reg <= 4'hC;
              st_reg   <= target_input_conditioner_pkg::S_DIV;
            end
          end
        end
        target_input_conditioner_pkg::S_DIV: begin
          if (rem2 >= {1'b0, den_reg}) begin
            rem_reg <= 13'(rem2 - {1'b0, den_reg});
            q_reg   <= {q_reg[11:0], 1'b1};
          end else begin
            rem_reg <= rem2[12:0];
            q_reg   <= {q_reg[11:0], 1'b0};
          end
          step_reg <= step_reg - 4'h1;
          if (step_reg == 4'h1) st_reg <= target_input_conditioner_pkg::S_POW;
        end
        target_input_conditioner_pkg::S_POW: begin
          if (lin_reg != q_reg && pow_reg == (degree > 2'h1 ? degree - 2'h1 : 2'h0)) begin
            lin_reg <= q_reg;
          end else if (pow_reg != 2'h0) begin
            q_reg   <= sq[24:12];
            pow_reg <= pow_reg - 2'h1;
          end else begin
            st_reg <= target_input_conditioner_pkg::S_OUT;
          end
        end
        target_input_conditioner_pkg::S_OUT: begin
          target_o <= 12'($signed({2'h0, n_tgt}) + 14'(prod >>> 12));
          st_reg   <= target_input_conditioner_pkg::S_IDLE;
        end
        default: st_reg <= target_input_conditioner_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= 32'h0;
    else if (!rd_i || addr_i[1:0] != 2'h0) rdata_o <= 32'h0;
    else if (addr_i < `ADDR_VALUES) rdata_o <= cfg_reg[addr_i[4:2]];
    else if (addr_i == `ADDR_VALUES) rdata_o <= {4'h0, target_o, 4'h0, raw_reg};
    else if (addr_i == `ADDR_FLAGS) rdata_o <= {28'h0, period_overrun_flag_o,
                                                serial_to_err_o, range_err_o, stale_err_o};
    else rdata_o <= 32'h0;
  end
endmodule : target_input_conditioner
`default_nettype wire

// >>> design/target_input_conditioner_cfg.svh
// Offsets, fields, reset values and timing counts of the input conditioner.
// Assumes a 250 MHz system clock and word-aligned byte addresses.
`ifndef TARGET_INPUT_CONDITIONER_CFG_SVH
`define TARGET_INPUT_CONDITIONER_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CTRL    8'h00
`define ADDR_PERIOD  8'h04
`define ADDR_INRANGE 8'h08
`define ADDR_NEUTRAL 8'h0C
`define ADDR_ABS     8'h10
`define ADDR_TGT     8'h14
`define ADDR_NTGT    8'h18
`define ADDR_VALUES  8'h1C
`define ADDR_FLAGS   8'h20
`define NUM_CFG      7
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CTRL    32'h0000_0000
`define RST_PERIOD  32'h0000_0001
`define RST_RANGE   32'h0FFF_0000
`define RST_NEUTRAL 32'h0800_0800
`define RST_NTGT    32'h0000_0800
// ----------------------------------------
// Fields
// ----------------------------------------
`define MODE_SERIAL 2'h0
`define MODE_ANALOG 2'h1
`define MODE_PULSE  2'h2
`define FLAG_OVERRUN 3
`define FULL_FRAC   13'h1000
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ       250
`define TICK_ADD      3
`define TICK_WRAP     (2 * `CLK_MHZ)
`define PULSE_MIN_US  400
`define PULSE_MAX_US  2600
`define PULSE_MIN_TK  (`PULSE_MIN_US * `TICK_ADD / 2)
`define PULSE_MAX_TK  (`PULSE_MAX_US * `TICK_ADD / 2)
`define GOOD_PULSES   4
`define STALE_MS      120
`define STALE_CYCLES  (`STALE_MS * `CLK_MHZ * 1000)
`define MS_CYCLES     (`CLK_MHZ * 1000)
`define PROBE_US      150
`define PROBE_CYCLES  (`PROBE_US * `CLK_MHZ)
`define ADC_TO_RAW    2
`endif

// >>> design/target_input_conditioner_pkg.sv
// Types shared by the input conditioner and its users.
// Assumes the serial framing is decoded outside this block.
package target_input_conditioner_pkg;
  typedef struct packed {
    logic        valid;
    logic [6:0]  unit;
    logic [11:0] target;
    logic        has_crc;
    logic        crc_ok;
  } serial_cmd_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_DIV  = 4'b0010,
    S_POW  = 4'b0100,
    S_OUT  = 4'b1000
  } scale_state_t;
endpackage : target_input_conditioner_pkg

// >>> dv/remote_input_model.sv
// Far side model: pulse source on the control pin and a potentiometer fed from aux.
// Assumes one conversion every four clocks; pulses are short, as valid widths outlast the run.
`timescale 1ns/1ns
`default_nettype none
module remote_input_model (
  input  wire logic       sys_clk_i,
  input  wire logic       aux_o,
  input  wire logic       aux_oe_o,
  input  wire logic       pulse_en,
  input  wire logic       alt,
  input  wire logic       open_wire,
  input  wire logic [9:0] level,
  output var  logic       rx_pin = 1'b0,
  output var  logic       adc_valid = 1'b0,
  output var  logic [9:0] adc_data = 10'h000
);
  logic [8:0] pcnt = 9'h000;
  logic [1:0] acnt = 2'h0;
  logic       odd = 1'b0;
  logic       pin_low;
  // ----------------------------------------
  // Pulse source, idle low between pulses
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    pcnt <= (pulse_en && pcnt != 9'h0EF) ? pcnt + 9'h001 : 9'h000;
    rx_pin <= pulse_en && pcnt < 9'h028;
  end
  // ----------------------------------------
  // Potentiometer between aux and ground
  // ----------------------------------------
  assign pin_low = aux_oe_o && !aux_o;
  always_ff @(posedge sys_clk_i) begin
    acnt <= acnt + 2'h1;
    adc_valid <= acnt == 2'h3;
    if (acnt == 2'h3) begin
      odd <= !odd;
      adc_data <= (pin_low && !open_wire) ? 10'h000 : level + ((alt && odd) ? 10'h002 : 10'h000);
    end else begin
      adc_data <= ~adc_data;
    end
  end
endmodule : remote_input_model
`default_nettype wire

// >>> dv/target_input_conditioner_props.sv
// Concurrent checks on the input conditioner ports.
// Assumes binding to the top module; control settings are shadowed from bus writes.
`timescale 1ns/1ns
`default_nettype none
module target_input_conditioner_props (
  input wire logic                                      sys_clk_i,
  input wire logic                                      rst_n_i,
  input wire logic [7:0]                                addr_i,
  input wire logic [31:0]                               wdata_i,
  input wire logic                                      wr_i,
  input wire logic                                      rd_i,
  input wire logic [31:0]                               rdata_o,
  input wire target_input_conditioner_pkg::serial_cmd_t cmd_i,
  input wire logic                                      adc_valid_i,
  input wire logic [9:0]                                adc_data_i,
  input wire logic                                      rx_pin_i,
  input wire logic                                      aux_o,
  input wire logic                                      aux_oe_o,
  input wire logic [11:0]                               target_o,
  input wire logic                                      stale_err_o,
  input wire logic                                      range_err_o,
  input wire logic                                      serial_to_err_o,
  input wire logic                                      period_overrun_flag_o
);
  logic [14:0] ctrl_reg;
  logic [15:0] tmo_reg;
  logic        ser;
  logic        acc;
  // ----------------------------------------
  // Shadow of control settings
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= 15'h0000;
    end else if (wr_i && addr_i == 8'h00) begin
      ctrl_reg <= wdata_i[14:0];
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_reg <= 16'h0000;
    end else if (wr_i && addr_i == 8'h18) begin
      tmo_reg <= wdata_i[31:16];
    end
  end
  assign ser = ctrl_reg[1:0] == 2'h0;
  assign acc = cmd_i.valid && ser && cmd_i.unit == ctrl_reg[14:8] && (!ctrl_reg[3] || (cmd_i.has_crc && cmd_i.crc_ok));
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_cmd_taken: assert property (acc |=> target_o == $past(cmd_i.target))
    else $error("command target not taken");
  chk_serial_only: assert property (ser && $past(ser) && $changed(target_o) |-> $past(acc))
    else $error("target moved without command");
  chk_crc_refused: assert property (cmd_i.valid && ser && ctrl_reg[3] && !(cmd_i.has_crc && cmd_i.crc_ok)
    |=> $stable(target_o)) else $error("command without good check byte taken");
  chk_unit_refused: assert property (cmd_i.valid && ser && cmd_i.unit != ctrl_reg[14:8]
    |=> $stable(target_o)) else $error("command for other unit taken");
  chk_probe_cause: assert property ($fell(aux_o) |-> ctrl_reg[4] && ctrl_reg[1:0] == 2'h1)
    else $error("aux driven low without probing");
  chk_probe_width: assert property ($fell(aux_o) |=> (!aux_o) [*6] ##[1:40] aux_o)
    else $error("probe low time wrong");
  chk_aux_driven: assert property ($past(rst_n_i) |-> aux_oe_o)
    else $error("aux not driven");
  chk_timeout_off: assert property ($rose(serial_to_err_o) |-> tmo_reg != 16'h0000)
    else $error("timeout error while disabled");
  chk_stale_mode: assert property ($rose(stale_err_o) |-> ctrl_reg[1:0] == 2'h2)
    else $error("stale error outside pulse mode");
  chk_overrun_hold: assert property ($fell(period_overrun_flag_o)
    |-> $past(wr_i && addr_i == 8'h20 && wdata_i[3])) else $error("overrun flag cleared without write");
  cov_cmd: cover property (acc);
  cov_probe: cover property ($fell(aux_o));
  cov_stale: cover property ($rose(stale_err_o));
endmodule : target_input_conditioner_props
bind target_input_conditioner target_input_conditioner_props target_input_conditioner_props_i (.sys_clk_i,
  .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmd_i, .adc_valid_i, .adc_data_i, .rx_pin_i, .aux_o,
  .aux_oe_o, .target_o, .stale_err_o, .range_err_o, .serial_to_err_o, .period_overrun_flag_o);
`default_nettype wire

// >>> dv/target_input_conditioner_tb_top.sv
// Self-checking bench for the input conditioner.
// Assumes the remote input model on the control pin and the conversion stream.
`timescale 1ns/1ns
`default_nettype none
module target_input_conditioner_tb_top;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  logic        adc_valid, rx_pin, aux_o, aux_oe_o, pulse_en, alt, open_wire;
  logic [9:0]  adc_data, level;
  logic [11:0] target_o;
  logic        stale_err_o, range_err_o, serial_to_err_o, period_overrun_flag_o;
  int          errors = 0;
  int          cmp_count = 0;
  target_input_conditioner_pkg::serial_cmd_t cmd_i;
  target_input_conditioner #(.MS_CYC(50), .STALE_CYC(2000), .PROBE_CYC(10)) target_input_conditioner_i (
    .sys_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmd_i, .adc_valid_i(adc_valid),
    .adc_data_i(adc_data), .rx_pin_i(rx_pin), .aux_o, .aux_oe_o, .target_o, .stale_err_o, .range_err_o,
    .serial_to_err_o, .period_overrun_flag_o);
  remote_input_model remote_input_model_i (.sys_clk_i, .aux_o, .aux_oe_o, .pulse_en, .alt, .open_wire,
    .level, .rx_pin, .adc_valid, .adc_data);
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    cmp(nm, e, rdata_o & m);
  endtask : rchk
  task automatic send(input logic [6:0] u, input logic [11:0] t, input logic [1:0] c);
    @(posedge sys_clk_i);
    cmd_i <= {1'b1, u, t, c};
    @(posedge sys_clk_i);
    cmd_i.valid <= 1'b0;
  endtask : send
  function automatic logic [31:0] obs(input int s);
    case (s)
      0: obs = {20'h00000, target_o};
      1: obs = {31'h0, stale_err_o};
      2: obs = {31'h0, range_err_o};
      3: obs = {31'h0, serial_to_err_o};
      4: obs = {31'h0, period_overrun_flag_o};
      default: obs = {31'h0, aux_o};
    endcase
  endfunction : obs
  task automatic expect_sig(input string nm, input int s, input logic [31:0] e);
    int n = 0;
    #1;
    while (obs(s) !== e && n < 5000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    cmp(nm, e, obs(s));
    if (obs(s) !== e) complete_run();
  endtask : expect_sig
  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    {rst_n_i, addr_i, wdata_i, wr_i, rd_i, cmd_i, pulse_en, alt, open_wire, level} = '0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rchk("ctrl", 8'h00, 32'h0);
    rchk("period", 8'h04, 32'h1);
    rchk("inrange", 8'h08, 32'h0FFF_0000);
    rchk("neutral", 8'h0C, 32'h0800_0800);
    rchk("ntgt", 8'h18, 32'h0000_0800);
    wr(8'h1C, 32'hFFFF_FFFF);
    rchk("values_ro", 8'h1C, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    $display("register test done");
    wr(8'h00, 32'h0000_0500);
    send(7'h05, 12'h123, 2'h0);
    expect_sig("cmd", 0, 32'h123);
    send(7'h06, 12'h456, 2'h0);
    repeat (4) @(posedge sys_clk_i);
    expect_sig("unit", 0, 32'h123);
    wr(8'h00, 32'h0000_0508);
    send(7'h05, 12'h456, 2'h0);
    send(7'h05, 12'h456, 2'h2);
    repeat (4) @(posedge sys_clk_i);
    expect_sig("crc_bad", 0, 32'h123);
    send(7'h05, 12'h789, 2'h3);
    expect_sig("crc_good", 0, 32'h789);
    rchk("raw_cmd", 8'h1C, 32'h789, 32'hFFF);
    wr(8'h18, 32'h0002_0800);
    expect_sig("tmo_set", 3, 32'h1);
    send(7'h05, 12'h789, 2'h3);
    expect_sig("tmo_clr", 3, 32'h0);
    wr(8'h18, 32'h0000_0800);
    repeat (400) @(posedge sys_clk_i);
    expect_sig("tmo_off", 3, 32'h0);
    $display("serial test done");
    wr(8'h00, 32'h0000_0002);
    pulse_en <= 1'b1;
    expect_sig("stale", 1, 32'h1);
    rchk("raw_hold", 8'h1C, 32'h789, 32'hFFF);
    pulse_en <= 1'b0;
    $display("pulse test done");
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h0FFC_0000);
    level <= 10'h3FF;
    expect_sig("in_max", 0, 32'hFFF);
    rchk("raw_full", 8'h1C, 32'hFFC, 32'hFFF);
    level <= 10'h000;
    expect_sig("in_min", 0, 32'h0);
    wr(8'h00, 32'h0000_0005);
    expect_sig("inv_min", 0, 32'hFFF);
    level <= 10'h3FF;
    expect_sig("inv_max", 0, 32'h0);
    wr(8'h00, 32'h0000_0001);
    wr(8'h0C, 32'h0C00_0400);
    level <= 10'h12C;
    expect_sig("dead_band", 0, 32'h800);
    wr(8'h0C, 32'h0800_0800);
    wr(8'h00, 32'h0000_0041);
    level <= 10'h300;
    repeat (400) @(posedge sys_clk_i);
    cmp("degree", 32'h1, {31'h0, target_o > 12'h800 && target_o < 12'hA8C});
    wr(8'h00, 32'h0000_0001);
    wr(8'h04, 32'h0000_0201);
    alt <= 1'b1;
    level <= 10'h1F4;
    expect_sig("avg_tgt", 0, 32'h7D4);
    rchk("avg_raw", 8'h1C, 32'h7D4, 32'hFFF);
    alt <= 1'b0;
    wr(8'h04, 32'h0000_0001);
    wr(8'h10, 32'h0FFF_0064);
    level <= 10'h000;
    expect_sig("abs_low", 2, 32'h1);
    rchk("flag_range", 8'h20, 32'h2, 32'h2);
    level <= 10'h200;
    expect_sig("abs_ok", 2, 32'h0);
    wr(8'h10, 32'h0FFF_0000);
    wr(8'h04, 32'h0000_0701);
    expect_sig("overrun", 4, 32'h1);
    wr(8'h04, 32'h0000_0001);
    repeat (200) @(posedge sys_clk_i);
    wr(8'h20, 32'h0000_0008);
    expect_sig("overrun_clr", 4, 32'h0);
    $display("analog test done");
    wr(8'h00, 32'h0000_0011);
    expect_sig("probe_low", 5, 32'h0);
    repeat (400) @(posedge sys_clk_i);
    expect_sig("probe_ok", 2, 32'h0);
    open_wire <= 1'b1;
    expect_sig("probe_open", 2, 32'h1);
    $display("probe test done");
    complete_run();
  end
endmodule : target_input_conditioner_tb_top
`default_nettype wire
